// ---- i2cef_cdc_if.sv ----
// Crossing signals between the register side and the link engine
`timescale 1ns/10ps
interface i2cef_cdc_if;
  logic go_tgl;       // Toggled by the bus side to launch a command
  logic [8:0] cmd;    // Command, stable while a launch is in flight
  logic ack_tgl;      // Toggled by the bus side when software clears the done-without-stop flag
  logic ev_tgl;       // Toggled by the link side on every event
  logic [3:0] ev_tag; // Event tag, stable across each event toggle
  modport bus(output go_tgl, output cmd, output ack_tgl, input ev_tgl, input ev_tag);
  modport link(input go_tgl, input cmd, input ack_tgl, output ev_tgl, output ev_tag);
endinterface

// ---- i2cef_link.sv ----
// Serial line engine on the link clock: arbitration, bus errors, clock holding
//
// Local design decisions: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
`include "i2cef_map.svh"
module i2cef_link (
  // Link clock and reset
  input wire logic lclk,
  input wire logic rst,
  // Crossing to the register side
  i2cef_cdc_if.link cdc,
  // Serial pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe,
  output logic sda_oe
);
  i2cef_pkg::i2cef_state_t st_reg;
  logic [1:0] go_s, ack_s, scl_s, sda_s; // Two-stage synchronisers
  logic go_seen_reg, ack_seen_reg;
  logic [8:0] cmd_reg;                   // Latched command, reused on retry
  logic [3:0] cnt_reg;
  logic [3:0] bitn_reg;
  logic phase_reg;                       // 0 low half, 1 high half
  logic sda_d_reg, scl_d_reg;            // Previous synchronised levels
  logic ev_tgl_reg;
  logic [3:0] tag_reg;
  logic busy_reg;                        // Bus owned by someone (start seen)
  wire go_ev = go_s[1] ^ go_seen_reg;
  wire ack_ev = ack_s[1] ^ ack_seen_reg;
  wire half_done = (cnt_reg == `I2CEF_HALF_CNT);
  // Start and stop seen on the line, only while clock is high
  wire start_det = scl_s[1] && scl_d_reg && sda_d_reg && !sda_s[1];
  wire stop_det = scl_s[1] && scl_d_reg && !sda_d_reg && sda_s[1];
  // Address frame, MSB first; last bit is read/write
  wire [7:0] frame = {cmd_reg[`I2CEF_CMD_ADDR_MSB:`I2CEF_CMD_ADDR_LSB],
                      cmd_reg[`I2CEF_CMD_RD_BIT]};
  wire tx_bit = frame[3'(7 - bitn_reg[2:0])];
  // Released high but line low while clock high: collision. Judged only at the end
  // of the high half, since the pin path lags the engine by about four link cycles
  wire collide = (st_reg == i2cef_pkg::I2CEF_BIT) && phase_reg && half_done && tx_bit &&
                 (bitn_reg < 4'h8) && !sda_s[1];
  assign cdc.ev_tgl = ev_tgl_reg;
  assign cdc.ev_tag = tag_reg;

  // Synchronisers for pins and toggles
  always_ff @(posedge lclk or posedge rst) begin
    if (rst) begin
      go_s <= 2'h0;
      ack_s <= 2'h0;
      scl_s <= 2'h3;
      sda_s <= 2'h3;
    end else begin
      go_s <= {go_s[0], cdc.go_tgl};
      ack_s <= {ack_s[0], cdc.ack_tgl};
      scl_s <= {scl_s[0], scl_i};
      sda_s <= {sda_s[0], sda_i};
    end
  end

  // Edge history and bus-busy tracking
  always_ff @(posedge lclk or posedge rst) begin
    if (rst) begin
      sda_d_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      busy_reg <= 1'b0;
    end else begin
      sda_d_reg <= sda_s[1];
      scl_d_reg <= scl_s[1];
      if (stop_det) begin
        busy_reg <= 1'b0;
      end else if (start_det) begin
        busy_reg <= 1'b1;
      end
    end
  end

  // Engine: start, address bits with ack slot, stop or hold
  always_ff @(posedge lclk or posedge rst) begin
    if (rst) begin
      st_reg <= i2cef_pkg::I2CEF_IDLE;
      go_seen_reg <= 1'b0;
      ack_seen_reg <= 1'b0;
      cmd_reg <= `I2CEF_CMD_RST;
      cnt_reg <= 4'h0;
      bitn_reg <= 4'h0;
      phase_reg <= 1'b0;
      ev_tgl_reg <= 1'b0;
      tag_reg <= `I2CEF_TAG_NONE;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      cnt_reg <= half_done ? 4'h0 : cnt_reg + 4'h1;
      unique case (st_reg)
        i2cef_pkg::I2CEF_IDLE: begin
          scl_oe <= 1'b0;
          sda_oe <= 1'b0;
          if (go_ev && !busy_reg) begin
            go_seen_reg <= go_s[1];
            cmd_reg <= cdc.cmd;
            st_reg <= i2cef_pkg::I2CEF_START;
            cnt_reg <= 4'h0;
          end
        end
        i2cef_pkg::I2CEF_START: begin
          sda_oe <= 1'b1;
          if (half_done) begin
            scl_oe <= 1'b1;
            bitn_reg <= 4'h0;
            phase_reg <= 1'b0;
            st_reg <= i2cef_pkg::I2CEF_BIT;
          end
        end
        i2cef_pkg::I2CEF_BIT: begin
          if (collide) begin
            // Leave the bus at once and wait for the line to go idle
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            tag_reg <= `I2CEF_TAG_ARB;
            ev_tgl_reg <= ~ev_tgl_reg;
            st_reg <= i2cef_pkg::I2CEF_WAIT;
          end else if (phase_reg && (start_det || stop_det)) begin
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            tag_reg <= `I2CEF_TAG_BUS_ERROR_FLAG;
            ev_tgl_reg <= ~ev_tgl_reg;
            st_reg <= i2cef_pkg::I2CEF_IDLE;
          end else if (half_done) begin
            phase_reg <= ~phase_reg;
            scl_oe <= phase_reg;
            if (!phase_reg) begin
              // Data changes only in the low half; ack slot released
              sda_oe <= (bitn_reg < 4'h8) ? !tx_bit : 1'b0;
            end else if (bitn_reg == 4'h8) begin
              sda_oe <= 1'b1;
              if (cmd_reg[`I2CEF_CMD_STOP_BIT]) begin
                st_reg <= i2cef_pkg::I2CEF_STOP;
              end else begin
                // No stop requested: keep clock low until acknowledged
                tag_reg <= `I2CEF_TAG_NONE;
                ev_tgl_reg <= ~ev_tgl_reg;
                st_reg <= i2cef_pkg::I2CEF_HOLD;
              end
            end else begin
              bitn_reg <= bitn_reg + 4'h1;
            end
          end
        end
        i2cef_pkg::I2CEF_STOP: begin
          if (half_done) begin
            if (scl_oe) begin
              scl_oe <= 1'b0;
            end else begin
              sda_oe <= 1'b0;
              // A stop closing a held frame reports nothing new
              if (cmd_reg[`I2CEF_CMD_STOP_BIT]) begin
                tag_reg <= `I2CEF_TAG_OK;
                ev_tgl_reg <= ~ev_tgl_reg;
              end
              st_reg <= i2cef_pkg::I2CEF_IDLE;
            end
          end
        end
        i2cef_pkg::I2CEF_HOLD: begin
          scl_oe <= 1'b1;
          if (ack_ev) begin
            // Release through a stop, else the bus stays busy and no command starts
            ack_seen_reg <= ack_s[1];
            st_reg <= i2cef_pkg::I2CEF_STOP;
          end
        end
        i2cef_pkg::I2CEF_WAIT: begin
          scl_oe <= 1'b0;
          sda_oe <= 1'b0;
          if (stop_det) begin
            st_reg <= i2cef_pkg::I2CEF_START;
            cnt_reg <= 4'h0;
          end
        end
        default: st_reg <= i2cef_pkg::I2CEF_IDLE;
      endcase
      if (st_reg != i2cef_pkg::I2CEF_HOLD && ack_ev) begin
        ack_seen_reg <= ack_s[1];
      end
    end
  end
endmodule

// ---- i2cef_map.svh ----
// Register offsets, field positions, codes and timing for the I2C error/done flag block
`ifndef I2CEF_MAP_SVH
`define I2CEF_MAP_SVH
// Register byte offsets
`define I2CEF_RAW_FLAGS_OFF 4'h0
`define I2CEF_CLEAR_OFF 4'h4
`define I2CEF_CMD_OFF 4'h8
`define I2CEF_STATUS_OFF 4'hc
// Raw flag bit positions
`define I2CEF_DONE_BIT 19
`define I2CEF_ARB_BIT 24
`define I2CEF_BUS_ERROR_FLAG_BIT 25
`define I2CEF_DNS_BIT 28
// Command register fields
`define I2CEF_CMD_RD_BIT 0
`define I2CEF_CMD_STOP_BIT 1
`define I2CEF_CMD_ADDR_LSB 2
`define I2CEF_CMD_ADDR_MSB 8
// Error tag codes held in the status word
`define I2CEF_TAG_NONE 4'h0
`define I2CEF_TAG_ARB 4'h1
`define I2CEF_TAG_BUS_ERROR_FLAG 4'h2
`define I2CEF_TAG_OK 4'h3
// Reset values
`define I2CEF_RAW_RST 32'h0000_0000
`define I2CEF_CMD_RST 9'h000
// Last count of each half period of the generated serial clock; a half lasts five link clock cycles
`define I2CEF_HALF_CNT 4'h4
`endif

// ---- i2cef_peer.sv ----
// Second station on the serial bus that contends or breaks frames when told to
`timescale 1ns/10ps
module i2cef_peer (
  // Link clock and reset
  input wire logic lclk,
  input wire logic rst,
  // 0 quiet, 1 contend, 2 start inside a frame
  input wire logic [1:0] mode,
  // Wired bus levels and this station's pull-down
  input wire logic scl,
  input wire logic sda,
  output logic sda_low
);
  logic scl_d;
  logic sda_d;
  logic [3:0] rises; // Clock rises since the last start
  logic [6:0] hold; // Cycles left on the pull-down
  // Start detection, bit count and pull-down timing
  always_ff @(posedge lclk or posedge rst) begin
    if (rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      rises <= 4'h0;
      hold <= 7'h0;
      sda_low <= 1'b0;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
      if (scl && scl_d && sda_d && !sda) begin
        rises <= 4'h0;
      end else if (scl && !scl_d && rises != 4'hf) begin
        rises <= rises + 4'h1;
      end
      if (hold != 7'h0) begin
        hold <= hold - 7'h1;
        // Letting go while the clock is high closes the frame with a stop
        sda_low <= (hold != 7'h1);
      end else if (mode == 2'h1 && rises == 4'h0 && scl_d && !scl) begin
        // A zero under the device's released first bit wins the bus
        sda_low <= 1'b1;
        hold <= 7'h64;
      end else if (mode == 2'h2 && rises == 4'h8 && scl && !scl_d) begin
        // Data falling in the ninth clock's high phase is a start mid-frame
        sda_low <= 1'b1;
        hold <= 7'h8;
      end
    end
  end
endmodule

// ---- i2cef_pkg.sv ----
// Types shared by the I2C error/done flag block
package i2cef_pkg;
  // Link engine states
  typedef enum logic [2:0] {
    I2CEF_IDLE = 3'b000,
    I2CEF_START = 3'b001,
    I2CEF_BIT = 3'b010,
    I2CEF_STOP = 3'b011,
    I2CEF_HOLD = 3'b100,
    I2CEF_WAIT = 3'b101
  } i2cef_state_t;
endpackage

// ---- i2cef_props.sv ----
// Checker of the flag block's bus answers and serial pin behaviour
`timescale 1ns/10ps
`include "i2cef_map.svh"
module i2cef_props (
  // Clocks and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic lclk,
  // Wishbone slave side
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Serial pins
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // A request taken, and the answers to flag and status reads
  sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence flag_rd_s; wb_ack_o && !wb_we_i && wb_adr_i == `I2CEF_RAW_FLAGS_OFF; endsequence
  sequence stat_rd_s; wb_ack_o && !wb_we_i && wb_adr_i == `I2CEF_STATUS_OFF; endsequence
  ack_answer_a: assert property (req_s |=> wb_ack_o)
    else $error("no ack one cycle after a request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  dat_quiet_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data driven outside ack");
  reserved_zero_a: assert property (flag_rd_s |-> wb_dat_o[31:29] == 3'h0 && wb_dat_o[27:26] == 2'h0)
    else $error("reserved flag bits not zero");
  flag_mask_a: assert property (flag_rd_s |-> (wb_dat_o & 32'hecf7_ffff) == 32'h0)
    else $error("flag word has bits outside the flag set");
  held_clock_a: assert property (flag_rd_s ##0 wb_dat_o[`I2CEF_DNS_BIT] |-> scl_oe)
    else $error("clock line released while done-without-stop stands");
  tag_legal_a: assert property (stat_rd_s |-> wb_dat_o[31:5] == 27'h0 && wb_dat_o[3:0] <= 4'h3)
    else $error("status word holds an unknown tag");
  open_drain_a: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("serial line driven high");
  reset_quiet_a: assert property ($fell(rst) |-> !wb_ack_o && !scl_oe && !sda_oe)
    else $error("outputs active right after reset");
endmodule
bind i2cef_top i2cef_props i_props (.mclk, .rst, .lclk, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .scl_i, .scl_o, .scl_oe, .sda_i,
  .sda_o, .sda_oe);

// ---- i2cef_top.sv ----
// Wishbone register side of the I2C error/done flag block
`timescale 1ns/10ps
`include "i2cef_map.svh"
module i2cef_top (
  // System clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Link clock
  input wire logic lclk,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Serial pins, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  i2cef_cdc_if cdc();
  logic scl_oe_l, sda_oe_l;  // Engine drives, link domain
  logic [1:0] scl_oe_s, sda_oe_s;
  logic go_tgl_reg, ack_tgl_reg;
  logic [8:0] cmd_reg;       // Controller command register
  logic [3:0] tag_reg;       // Error tag field of the status word
  logic [31:0] raw_reg;      // Raw interrupt flags
  logic [31:0] raw_next;
  logic [2:0] ev_s;          // Event toggle sync plus history
  logic [1:0] ack_pend_reg;  // Done-without-stop flag still awaiting clear (bit 0 only, bit 1 held at 0)
  logic busy_reg;            // Command issued, result not back
  assign cdc.go_tgl = go_tgl_reg;
  assign cdc.cmd = cmd_reg;
  assign cdc.ack_tgl = ack_tgl_reg;

  i2cef_link u_link (
    .lclk(lclk),
    .rst(rst),
    .cdc(cdc),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .scl_oe(scl_oe_l),
    .sda_oe(sda_oe_l)
  );

  // Bus decode
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr = req && wb_we_i && wb_sel_i[3] && wb_sel_i[2] && wb_sel_i[1] && wb_sel_i[0];
  wire hit_raw = (wb_adr_i == `I2CEF_RAW_FLAGS_OFF);
  wire hit_clr = (wb_adr_i == `I2CEF_CLEAR_OFF);
  wire hit_cmd = (wb_adr_i == `I2CEF_CMD_OFF);
  wire hit_st = (wb_adr_i == `I2CEF_STATUS_OFF);
  wire [31:0] clr_mask = (wr && hit_clr) ? wb_dat_i : 32'h0;
  wire ev_pulse = ev_s[2] ^ ev_s[1];
  wire [3:0] ev_tag = cdc.ev_tag;
  // Done flag outstanding blocks a new command
  wire hold_flag = raw_reg[`I2CEF_DNS_BIT] || raw_reg[`I2CEF_DONE_BIT];
  wire cmd_ok = wr && hit_cmd && !hold_flag && !busy_reg;
  wire ack_fire = ack_pend_reg[0] && clr_mask[`I2CEF_DNS_BIT];
  wire [31:0] rd_mux = hit_raw ? raw_reg :
                       hit_cmd ? {23'h0, cmd_reg} :
                       hit_st ? {27'h0, busy_reg, tag_reg} : 32'h0;

  // Flag set/clear; an event in the clear cycle wins
  always_comb begin
    raw_next = raw_reg & ~clr_mask;
    if (ev_pulse) begin
      unique case (ev_tag)
        `I2CEF_TAG_ARB: raw_next[`I2CEF_ARB_BIT] = 1'b1;
        `I2CEF_TAG_BUS_ERROR_FLAG: raw_next[`I2CEF_BUS_ERROR_FLAG_BIT] = 1'b1;
        `I2CEF_TAG_NONE: raw_next[`I2CEF_DNS_BIT] = 1'b1;
        `I2CEF_TAG_OK: raw_next[`I2CEF_DONE_BIT] = 1'b1;
        default: raw_next = raw_reg & ~clr_mask;
      endcase
    end
    // Reserved and out-of-scope bits never set
    raw_next = raw_next & ((32'h1 << `I2CEF_DONE_BIT) | (32'h1 << `I2CEF_ARB_BIT) |
               (32'h1 << `I2CEF_BUS_ERROR_FLAG_BIT) | (32'h1 << `I2CEF_DNS_BIT));
  end

  // Event toggle synchroniser, third stage only for edge detect
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ev_s <= 3'h0;
    end else begin
      ev_s <= {ev_s[1:0], cdc.ev_tgl};
    end
  end

  // Pin enables come from the link domain
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scl_oe_s <= 2'h0;
      sda_oe_s <= 2'h0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      scl_oe_s <= {scl_oe_s[0], scl_oe_l};
      sda_oe_s <= {sda_oe_s[0], sda_oe_l};
      scl_oe <= scl_oe_s[1];
      sda_oe <= sda_oe_s[1];
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  // Flags, tag and tracking of the held clock
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      raw_reg <= `I2CEF_RAW_RST;
      tag_reg <= `I2CEF_TAG_NONE;
      busy_reg <= 1'b0;
      ack_pend_reg <= 2'h0;
      ack_tgl_reg <= 1'b0;
    end else begin
      raw_reg <= raw_next;
      if (ev_pulse) begin
        tag_reg <= ev_tag;
        // Arbitration loss retries on its own, so stays busy
        busy_reg <= (ev_tag == `I2CEF_TAG_ARB);
        ack_pend_reg[0] <= (ev_tag == `I2CEF_TAG_NONE);
      end else if (cmd_ok) begin
        busy_reg <= 1'b1;
      end else if (ack_fire) begin
        ack_pend_reg[0] <= 1'b0;
      end
      ack_pend_reg[1] <= 1'b0;
      if (ack_fire && !ev_pulse) begin
        ack_tgl_reg <= ~ack_tgl_reg;
      end
    end
  end

  // Command register and Wishbone answer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmd_reg <= `I2CEF_CMD_RST;
      go_tgl_reg <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_mux : 32'h0;
      if (cmd_ok) begin
        cmd_reg <= wb_dat_i[8:0];
        go_tgl_reg <= ~go_tgl_reg;
      end
    end
  end
endmodule

// ---- i2cef_top_bench.sv ----
// Self-checking bench for the I2C error and done flag block
`timescale 1ns/10ps
`include "i2cef_map.svh"
module i2cef_top_bench;
  localparam logic [3:0] RAW = `I2CEF_RAW_FLAGS_OFF;
  localparam logic [3:0] CLR = `I2CEF_CLEAR_OFF;
  localparam logic [3:0] CMD = `I2CEF_CMD_OFF;
  localparam logic [3:0] STA = `I2CEF_STATUS_OFF;
  localparam logic [31:0] F_DONE = 32'h0008_0000;
  localparam logic [31:0] F_ARB = 32'h0100_0000;
  localparam logic [31:0] F_BUS_ERROR_FLAG = 32'h0200_0000;
  localparam logic [31:0] F_DNS = 32'h1000_0000;
  logic mclk, lclk, rst, cyc, stb, we, ack, scl_o, scl_oe, sda_o, sda_oe, peer_low;
  logic [3:0] adr;
  logic [31:0] wdat, rdat, rd;
  logic [1:0] mode;
  int n_mismatch, tests_run, cycles;
  wire scl = !scl_oe; // Pull-ups on both lines
  wire sda = !(sda_oe || peer_low);
  i2cef_top i_i2cef_top (.mclk(mclk), .rst(rst), .lclk(lclk), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe));
  i2cef_peer i_i2cef_peer (.lclk(lclk), .rst(rst), .mode(mode), .scl(scl), .sda(sda),
    .sda_low(peer_low));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = !mclk;
  end
  // Link clock offset by 7 ns at its own rate; its edges still meet system clock edges every 600 ns, first at 175 ns
  initial begin
    lclk = 1'b0;
    #7;
    forever #24 lclk = !lclk;
  end
  // Hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // One classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      n_mismatch++;
      $display("Error wb ack expected 1 seen %b", ack);
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Read flags until a bit shows; bounded so a dead link cannot hang us
  task automatic poll(input int pos);
    int n;
    n = 0;
    do begin
      wb(1'b0, RAW, 32'h0);
      n++;
    end while (rd[pos] !== 1'b1 && n < 600);
  endtask
  task automatic t_reset();
    wb(1'b0, RAW, 32'h0);
    chk("flags at reset", 32'h0, rd);
    wb(1'b0, 4'h1, 32'h0);
    chk("unmapped read", 32'h0, rd);
    $display("Test reset done");
  endtask
  task automatic t_stop();
    wb(1'b1, CMD, 32'h0000_016a);
    poll(`I2CEF_DONE_BIT);
    chk("done flag", F_DONE, rd);
    wb(1'b0, STA, 32'h0);
    chk("tag ok", {28'h0, `I2CEF_TAG_OK}, {28'h0, rd[3:0]});
    wb(1'b1, RAW, 32'hffff_ffff);
    wb(1'b0, RAW, 32'h0);
    chk("flags after write", F_DONE, rd);
    wb(1'b1, CLR, F_DONE);
    wb(1'b0, RAW, 32'h0);
    chk("flags after clear", 32'h0, rd);
    $display("Test stop done");
  endtask
  task automatic t_nostop();
    wb(1'b1, CMD, 32'h0000_0169);
    poll(`I2CEF_DNS_BIT);
    chk("no-stop flag", F_DNS, rd);
    chk("clock held", 32'h1, {31'h0, scl_oe});
    wb(1'b0, STA, 32'h0);
    chk("tag no-stop", {28'h0, `I2CEF_TAG_NONE}, {28'h0, rd[3:0]});
    // Refused while the flag stands, so no done may follow
    wb(1'b1, CMD, 32'h0000_016a);
    repeat (300) @(posedge mclk);
    wb(1'b0, RAW, 32'h0);
    chk("command refused", F_DNS, rd);
    wb(1'b1, CLR, F_DNS);
    repeat (40) @(posedge mclk);
    wb(1'b0, RAW, 32'h0);
    chk("no-stop cleared", 32'h0, rd);
    chk("clock released", 32'h0, {31'h0, scl_oe});
    $display("Test no-stop done");
  endtask
  task automatic t_arb();
    mode <= 2'h1;
    wb(1'b1, CMD, 32'h0000_016a);
    poll(`I2CEF_ARB_BIT);
    chk("arb flag", F_ARB, rd & F_ARB);
    wb(1'b0, STA, 32'h0);
    chk("tag arb", {28'h0, `I2CEF_TAG_ARB}, {28'h0, rd[3:0]});
    mode <= 2'h0;
    wb(1'b1, CLR, F_ARB);
    poll(`I2CEF_DONE_BIT);
    chk("retry done", F_DONE, rd);
    wb(1'b1, CLR, F_DONE);
    $display("Test arbitration done");
  endtask
  task automatic t_bus_error_flag();
    mode <= 2'h2;
    wb(1'b1, CMD, 32'h0000_016a);
    poll(`I2CEF_BUS_ERROR_FLAG_BIT);
    chk("bus error flag", F_BUS_ERROR_FLAG, rd & F_BUS_ERROR_FLAG);
    wb(1'b0, STA, 32'h0);
    chk("tag bus_error_flag", {28'h0, `I2CEF_TAG_BUS_ERROR_FLAG}, {28'h0, rd[3:0]});
    mode <= 2'h0;
    wb(1'b1, CLR, F_BUS_ERROR_FLAG);
    wb(1'b0, RAW, 32'h0);
    chk("bus error cleared", 32'h0, rd & F_BUS_ERROR_FLAG);
    $display("Test bus error done");
  endtask
  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    wdat = 32'h0;
    mode = 2'h0;
    n_mismatch = 0;
    tests_run = 0;
    cycles = 0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_stop();
    t_nostop();
    t_arb();
    t_bus_error_flag();
    conclude();
  end
endmodule
